/* File: rtl/ltc_config_pins.sv */
// Operation
// - Mode pin: low hardware, high parallel host, mid-supply serial host.
// - Hardware mode, coder pin low selects zero-substitution coder.
// - Hardware mode, coder pin high selects plain AMI coding.
// - Host mode takes coder type from the coder-enable register bit.
// - Host mode: shared pin high bus style A, low style B with acknowledge.
// - Host mode: control port answers only while chip select is low.
// - Hardware mode: attenuator pin low transmit, high receive, open disabled.
`default_nettype none
module ltc_config_pins
  import ltc_pkg::*;
(
  input wire logic clock, // 20 MHz clock
  input wire logic rstn, // Synchronous reset
  input wire ltc_pkg::ltc_level_e modeLevel, // Mode pin level
  input wire logic coderSel, // Shared coder / bus style pin
  input wire ltc_pkg::ltc_level_e jaSelLevel, // Shared attenuator / chip select pin
  input wire logic coderEnBit, // Coder-enable register bit
  output logic hwMode, // Hardware mode active
  output logic hostParallel, // Parallel host mode active
  output logic hostSerial, // Serial host mode active
  output logic coderAmi, // Line coder is plain AMI
  output logic [1:0] jaPosition, // Attenuator placement
  output logic busStyle, // Host bus style
  output logic portSelect // Control port access enabled
);
  import ltc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Level helpers

  // Pad comparator hit for one level
  function automatic logic level_is(input ltc_level_e lvl, input ltc_level_e want);
    return (lvl == want);
  endfunction

  // Attenuator placement for a strapped pin level
  function automatic logic [1:0] ja_place(input ltc_level_e lvl);
    if (level_is(lvl, LVL_LOW)) begin
      return JA_TX;
    end else if (level_is(lvl, LVL_HIGH)) begin
      return JA_RX;
    end
    return JA_OFF;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode

  ltc_mode_e modeNxt;
  logic isHw;
  logic isPar;
  logic isSer;
  logic csLow;
  logic pinCoder;
  logic [1:0] pinJa;
  logic hostBus;
  logic coderAmiNxt;
  logic [1:0] jaNxt;
  logic busNxt;
  logic selNxt;

  // Anything off the rails reads as mid-supply
  assign modeNxt = level_is(modeLevel, LVL_LOW) ? MODE_HW :
                   level_is(modeLevel, LVL_HIGH) ? MODE_PAR : MODE_SER;
  assign isHw = (modeNxt == MODE_HW);
  assign isPar = (modeNxt == MODE_PAR);
  assign isSer = (modeNxt == MODE_SER);

  // Hardware-mode readings of the shared pins
  assign pinCoder = coderSel ? CODER_AMI : CODER_ZS;
  assign pinJa = ja_place(jaSelLevel);

  // Host-mode readings of the same pins
  assign hostBus = coderSel ? BUS_STYLE_A : BUS_STYLE_B;
  assign csLow = level_is(jaSelLevel, LVL_LOW);

  // Each shared pin feeds only the function of the decoded mode
  assign coderAmiNxt = isHw ? pinCoder : coderEnBit;
  assign jaNxt = isHw ? pinJa : JA_OFF;
  assign busNxt = isHw ? BUS_RST : hostBus;
  assign selNxt = !isHw && csLow;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Mode flags, one-hot
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hwMode <= (MODE_RST == MODE_HW);
      hostParallel <= (MODE_RST == MODE_PAR);
      hostSerial <= (MODE_RST == MODE_SER);
    end else begin
      hwMode <= isHw;
      hostParallel <= isPar;
      hostSerial <= isSer;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      coderAmi <= CODER_RST;
    end else begin
      coderAmi <= coderAmiNxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      jaPosition <= JA_RST;
    end else begin
      jaPosition <= jaNxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      busStyle <= BUS_RST;
    end else begin
      busStyle <= busNxt;
    end
  end

  // Control port gate, shut while in reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      portSelect <= SEL_RST;
    end else begin
      portSelect <= selNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Mode pin strapped on an edge that is not a reset edge
  sequence hw_strap_s;
    rstn && modeLevel == LVL_LOW;
  endsequence

  sequence par_strap_s;
    rstn && modeLevel == LVL_HIGH;
  endsequence

  sequence ser_strap_s;
    rstn && modeLevel == LVL_MID;
  endsequence

  sequence host_strap_s;
    rstn && modeLevel != LVL_LOW;
  endsequence

  // Host access with chip select low
  sequence host_cs_s;
    host_strap_s ##0 jaSelLevel == LVL_LOW;
  endsequence

  // Host mode with chip select released
  sequence host_idle_s;
    host_strap_s ##0 jaSelLevel != LVL_LOW;
  endsequence

  mode_map_a: assert property (@(posedge clock) disable iff (!rstn)
    par_strap_s |=> hostParallel && !hwMode && !hostSerial)
    else $error("mode decode wrong");

  mode_hw_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s |=> hwMode && !hostParallel && !hostSerial)
    else $error("hardware mode not decoded");

  mode_ser_a: assert property (@(posedge clock) disable iff (!rstn)
    ser_strap_s |=> hostSerial && !hwMode && !hostParallel)
    else $error("serial host mode not decoded");

  coder_zs_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s ##0 !coderSel |=> coderAmi == CODER_ZS)
    else $error("zero-substitution coder not chosen");

  coder_ami_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s ##0 coderSel |=> coderAmi == CODER_AMI)
    else $error("AMI coder not chosen");

  coder_bit_a: assert property (@(posedge clock) disable iff (!rstn)
    host_strap_s |=> coderAmi == $past(coderEnBit))
    else $error("coder bit ignored in host mode");

  bus_style_a: assert property (@(posedge clock) disable iff (!rstn)
    host_strap_s ##0 coderSel |=> busStyle == BUS_STYLE_A)
    else $error("bus style wrong");

  bus_ack_a: assert property (@(posedge clock) disable iff (!rstn)
    host_strap_s ##0 !coderSel |=> busStyle == BUS_STYLE_B)
    else $error("acknowledge bus style wrong");

  port_sel_a: assert property (@(posedge clock) disable iff (!rstn)
    portSelect |-> !hwMode && $past(jaSelLevel) == LVL_LOW)
    else $error("port enabled without chip select");

  port_open_a: assert property (@(posedge clock) disable iff (!rstn)
    host_cs_s |=> portSelect)
    else $error("port shut during access");

  port_shut_a: assert property (@(posedge clock) disable iff (!rstn)
    host_idle_s |=> !portSelect)
    else $error("port open without access");

  ja_tx_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s ##0 jaSelLevel == LVL_LOW |=> jaPosition == JA_TX)
    else $error("attenuator not in transmit path");

  ja_rx_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s ##0 jaSelLevel == LVL_HIGH |=> jaPosition == JA_RX)
    else $error("attenuator not in receive path");

  ja_pos_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s ##0 jaSelLevel == LVL_MID |=> jaPosition == JA_OFF)
    else $error("attenuator not disabled");

  ja_host_a: assert property (@(posedge clock) disable iff (!rstn)
    hostParallel || hostSerial |-> jaPosition == JA_OFF)
    else $error("attenuator pin used in host mode");

  hw_bus_a: assert property (@(posedge clock) disable iff (!rstn)
    hw_strap_s |=> busStyle == BUS_RST && !portSelect)
    else $error("host pins used in hardware mode");

  reset_state_a: assert property (@(posedge clock)
    !rstn |=> {hostSerial, hostParallel, hwMode} == MODE_RST && coderAmi == CODER_RST
      && jaPosition == JA_RST && busStyle == BUS_RST && portSelect == SEL_RST)
    else $error("outputs not at reset values");
endmodule
`default_nettype wire

/* File: rtl/ltc_pkg.sv */
`default_nettype none
package ltc_pkg;
  // Three-level pin as seen by the pad comparators
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_MID = 2'h1,
    LVL_HIGH = 2'h2
  } ltc_level_e;

  typedef enum logic [2:0] {
    MODE_HW = 3'h1,
    MODE_PAR = 3'h2,
    MODE_SER = 3'h4
  } ltc_mode_e;

  // Line coder kind
  localparam logic CODER_ZS = 1'h0;
  localparam logic CODER_AMI = 1'h1;
  // Attenuator placement codes
  localparam logic [1:0] JA_OFF = 2'h0;
  localparam logic [1:0] JA_TX = 2'h1;
  localparam logic [1:0] JA_RX = 2'h2;
  // Host bus style
  localparam logic BUS_STYLE_A = 1'h1;
  localparam logic BUS_STYLE_B = 1'h0;
  // Reset values
  localparam ltc_mode_e MODE_RST = MODE_HW;
  localparam logic CODER_RST = CODER_ZS;
  localparam logic [1:0] JA_RST = JA_OFF;
  localparam logic BUS_RST = BUS_STYLE_A;
  localparam logic SEL_RST = 1'h0;
endpackage
`default_nettype wire

/* File: dv/ltc_strap_model.sv */
`default_nettype none
module ltc_strap_model
  import ltc_pkg::*;
(
  input wire logic clock, // Clock
  input wire ltc_pkg::ltc_level_e mW, // Wanted mode
  input wire logic cW, // Wanted coder pin
  input wire ltc_pkg::ltc_level_e jW, // Wanted select pin
  input wire logic eW, // Wanted enable bit
  output var ltc_pkg::ltc_level_e modeLevel, // Mode pin
  output var logic coderSel, // Coder pin
  output var ltc_pkg::ltc_level_e jaSelLevel, // Select pin
  output var logic coderEnBit // Enable bit
);
  timeunit 1ns;
  timeprecision 1ns;
  // Straps and host bit follow the wanted values one edge later
  always @(posedge clock) begin
    modeLevel <= mW;
    coderSel <= cW;
    jaSelLevel <= jW;
    coderEnBit <= eW;
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ltc_pkg::*;
  logic clock = 1'h0, rstn = 1'h0, cW = 1'h0, eW = 1'h0, coderSel, coderEnBit;
  logic hwMode, hostParallel, hostSerial, coderAmi, busStyle, portSelect;
  logic [1:0] jaPosition;
  ltc_level_e mW = LVL_LOW, jW = LVL_HIGH, modeLevel, jaSelLevel;
  int fail_count = 0, samples_checked = 0;
  always #25 clock = ~clock;
  ltc_strap_model ltc_strap_model_i (.clock, .mW, .cW, .jW, .eW, .modeLevel, .coderSel,
    .jaSelLevel, .coderEnBit);
  ltc_config_pins ltc_config_pins_i (.clock, .rstn, .modeLevel, .coderSel, .jaSelLevel,
    .coderEnBit, .hwMode, .hostParallel, .hostSerial, .coderAmi, .jaPosition, .busStyle,
    .portSelect);
  task automatic chk(input logic [2:0] seen, exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input ltc_level_e m, input logic c, input ltc_level_e j, input logic e);
    @(posedge clock);
    mW <= m;
    cW <= c;
    jW <= j;
    eW <= e;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic hw_pins();
    ltc_level_e lv[3] = '{LVL_LOW, LVL_HIGH, LVL_MID};
    logic [1:0] ja[3] = '{JA_TX, JA_RX, JA_OFF};
    for (int i = 0; i < 3; i++) begin
      put(LVL_LOW, i[0], lv[i], ~i[0]);
      chk({hwMode, hostParallel, hostSerial}, 3'h4, "mode");
      chk(jaPosition, ja[i], "ja");
      chk(coderAmi, i[0], "coder");
      chk({busStyle, portSelect}, 3'h2, "bus");
    end
  endtask
  task automatic host_pins();
    put(LVL_HIGH, BUS_STYLE_B, LVL_LOW, CODER_AMI);
    chk({hwMode, hostParallel, hostSerial}, 3'h2, "mode");
    chk({coderAmi, busStyle, portSelect}, 3'h5, "host");
    chk(jaPosition, JA_OFF, "ja");
    put(LVL_MID, BUS_STYLE_A, LVL_HIGH, CODER_ZS);
    chk({hwMode, hostParallel, hostSerial}, 3'h1, "mode");
    chk({coderAmi, busStyle, portSelect}, 3'h2, "host");
  endtask
  task automatic host_access();
    put(LVL_HIGH, BUS_STYLE_A, LVL_HIGH, CODER_ZS);
    chk(portSelect, 1'h0, "idle select");
    put(LVL_HIGH, BUS_STYLE_A, LVL_LOW, CODER_ZS);
    chk(portSelect, 1'h1, "access select");
    repeat (2) @(posedge clock);
    #1;
    chk(portSelect, 1'h1, "held select");
    put(LVL_HIGH, BUS_STYLE_A, LVL_HIGH, CODER_ZS);
    chk(portSelect, 1'h0, "end select");
  endtask
  task automatic reset_mid();
    put(LVL_HIGH, BUS_STYLE_B, LVL_LOW, CODER_AMI);
    @(posedge clock);
    rstn <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    chk({hwMode, hostParallel, hostSerial}, 3'h4, "reset mode");
    chk({coderAmi, busStyle, portSelect}, 3'h2, "reset host");
    chk(jaPosition, JA_RST, "reset ja");
    @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    #1;
    chk({hwMode, hostParallel, hostSerial}, 3'h2, "rel mode");
    chk({coderAmi, busStyle, portSelect}, 3'h5, "rel host");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'h1;
    hw_pins();
    host_pins();
    host_access();
    reset_mid();
    close_out();
  end
  initial begin
    #20000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
